// ### rtl/wdc_watchdog.sv
// Watchdog control register, timeout counter, unlock sequence and timeout action.
// Assumes a core that presents one register write or instruction strobe per retired instruction.
`timescale 1ns/10ps
`default_nettype none
`include "wdc_cfg.svh"

module wdc_watchdog
    import wdc_pkg::*;
#(
    parameter logic [31:0] PERIOD_CYCLES = `WDC_PERIOD_DEFAULT
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       instr_done,
    input  wire logic       ctrl_wr,
    input  wire logic [7:0] ctrl_wdata,
    input  wire logic       supply_monitor_irq,
    input  wire logic       wdt_reset_seen,
    output logic      [7:0] watchdog_control,
    output logic            wdt_system_reset,
    output logic            wdt_irq,
    output logic            wdt_irq_high_prio
);

    // ****************************************
    // Register state
    // ****************************************
    logic [3:0]  pre_r;
    logic [3:0]  pre_nxt;
    logic        action_r;
    logic        action_nxt;
    logic        status_r;
    logic        status_nxt;
    logic        enable_r;
    logic        enable_nxt;
    logic [31:0] count_r;
    logic [31:0] count_nxt;
    logic        rst_pend_r;
    logic        irq_r;
    wdc_state_t  state_r;
    wdc_state_t  state_nxt;

    // ****************************************
    // Decode helpers
    // ****************************************
    // Picks one field bit out of a written control byte
    function automatic logic wr_bit(
        input logic [7:0] data,
        input logic [2:0] pos
    );
        wr_bit = data[pos];
    endfunction : wr_bit

    // ****************************************
    // Write decode
    // ****************************************
    wire logic unlock_w   = (state_r == WDC_UNLOCK);
    wire logic wr_unlock  = wr_bit(ctrl_wdata, 3'(`WDC_BIT_UNLOCK));
    wire logic wr_enable  = wr_bit(ctrl_wdata, 3'(`WDC_BIT_ENABLE));
    wire logic wr_status  = wr_bit(ctrl_wdata, 3'(`WDC_BIT_STATUS));
    wire logic wr_action  = wr_bit(ctrl_wdata, 3'(`WDC_BIT_ACTION));
    wire logic set_unlock = ctrl_wr && wr_unlock && !unlock_w;
    wire logic write_ok   = ctrl_wr && unlock_w;
    wire logic unlock_end = instr_done || ctrl_wr;
    wire logic kick       = write_ok && wr_enable;
    wire logic status_clr = write_ok && !wr_status;

    // ****************************************
    // Timeout decode
    // ****************************************
    wire logic at_limit   = (count_r == PERIOD_CYCLES - 32'd1);
    wire logic expire     = enable_r && !kick && at_limit;
    wire logic act_reset  = expire && !action_r;
    wire logic act_irq    = expire && action_r;
    wire logic enable_clr = supply_monitor_irq || act_reset || wdt_reset_seen;

    // ****************************************
    // Next values
    // ****************************************
    assign pre_nxt    = write_ok ? ctrl_wdata[`WDC_PRE_LSB +: 4] : pre_r;
    assign action_nxt = write_ok ? wr_action : action_r;
    // Timeout wins over a software clear in the same cycle
    assign status_nxt = expire ? 1'b1 : (status_clr ? 1'b0 : status_r);
    assign enable_nxt = enable_clr ? 1'b0 : (write_ok ? wr_enable : enable_r);
    assign count_nxt  = (!enable_r || kick || expire) ? 32'h0 : count_r + 32'h1;

    // ****************************************
    // Unlock sequence
    // ****************************************
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            WDC_IDLE: begin
                if (set_unlock) begin
                    state_nxt = WDC_UNLOCK;
                end else if (enable_r) begin
                    state_nxt = WDC_ARMED;
                end else begin
                    state_nxt = WDC_IDLE;
                end
            end
            WDC_ARMED: begin
                if (set_unlock) begin
                    state_nxt = WDC_UNLOCK;
                end else if (enable_r) begin
                    state_nxt = WDC_ARMED;
                end else begin
                    state_nxt = WDC_IDLE;
                end
            end
            WDC_UNLOCK: begin
                // Window closes after one instruction or write
                if (unlock_end) begin
                    state_nxt = enable_r ? WDC_ARMED : WDC_IDLE;
                end else begin
                    state_nxt = WDC_UNLOCK;
                end
            end
            default: begin
                state_nxt = WDC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= WDC_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ****************************************
    // Setting fields
    // ****************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pre_r <= `WDC_PRE_RESET;
        end else begin
            pre_r <= pre_nxt;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            action_r <= `WDC_ACTION_RESET;
        end else begin
            action_r <= action_nxt;
        end
    end

    // ****************************************
    // Status flag
    // ****************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            status_r <= `WDC_STATUS_RESET;
        end else begin
            status_r <= status_nxt;
        end
    end

    // ****************************************
    // Enable bit
    // ****************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            enable_r <= `WDC_ENABLE_RESET;
        end else begin
            enable_r <= enable_nxt;
        end
    end

    // ****************************************
    // Timeout counter
    // ****************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count_r <= 32'h0;
        end else begin
            count_r <= count_nxt;
        end
    end

    // ****************************************
    // Timeout action
    // ****************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rst_pend_r <= 1'b0;
        end else begin
            rst_pend_r <= act_reset;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= act_irq;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign watchdog_control  = {pre_r, action_r, status_r, enable_r, unlock_w};
    assign wdt_system_reset  = rst_pend_r;
    assign wdt_irq           = irq_r;
    // Interrupt always carries the fixed high priority
    assign wdt_irq_high_prio = irq_r;

endmodule : wdc_watchdog
`default_nettype wire

// ### rtl/wdc_cfg.svh
// Constants for the watchdog control unit: bit positions, reset values, timing.
// Assumes inclusion by the package and the watchdog module only.
`ifndef WDC_CFG_SVH
`define WDC_CFG_SVH
`define WDC_BIT_UNLOCK      0
`define WDC_BIT_ENABLE      1
`define WDC_BIT_STATUS      2
`define WDC_BIT_ACTION      3
`define WDC_PRE_LSB         4
`define WDC_CTRL_RESET      8'h10
`define WDC_PRE_RESET       4'h1
`define WDC_ACTION_RESET    1'b0
`define WDC_STATUS_RESET    1'b0
`define WDC_ENABLE_RESET    1'b0
`define WDC_PERIOD_DEFAULT  32'd2000000
`endif

// ### rtl/wdc_pkg.sv
// Types shared by the watchdog control unit.
// Assumes the constants header sits beside it.
`include "wdc_cfg.svh"
package wdc_pkg;
    typedef enum logic [1:0] {
        WDC_IDLE   = 2'b00,
        WDC_ARMED  = 2'b01,
        WDC_UNLOCK = 2'b11
    } wdc_state_t;
endpackage : wdc_pkg

// ### sim/wdc_watchdog_checker.sv
// Port checker for the watchdog control unit.
// Bound into wdc_watchdog; sees its ports only.
`timescale 1ns/10ps
`default_nettype none
module wdc_watchdog_checker (
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       instr_done,
    input wire logic       ctrl_wr,
    input wire logic [7:0] ctrl_wdata,
    input wire logic       supply_monitor_irq,
    input wire logic       wdt_reset_seen,
    input wire logic [7:0] watchdog_control,
    input wire logic       wdt_system_reset,
    input wire logic       wdt_irq,
    input wire logic       wdt_irq_high_prio
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    wire logic [7:0] wc     = watchdog_control;
    wire logic       open_w = ctrl_wr && wc[0];
    property p_pri; wdt_irq_high_prio == wdt_irq; endproperty
    a_pri: assert property (p_pri) else $error("prio");
    property p_irq; wdt_irq |-> wc[2] && wc[3]; endproperty
    a_irq: assert property (p_irq) else $error("irq");
    property p_rst; wdt_system_reset |-> wc[2] && !wc[3] && !wc[1]; endproperty
    a_rst: assert property (p_rst) else $error("reset");
    property p_lock; ctrl_wr && !wc[0] && !ctrl_wdata[0] |=> $stable(wc[7:3]); endproperty
    a_lock: assert property (p_lock) else $error("lock");
    property p_drop; instr_done && !ctrl_wr |=> !wc[0]; endproperty
    a_drop: assert property (p_drop) else $error("drop");
    property p_kick; open_w && ctrl_wdata[1] && !supply_monitor_irq && !wdt_reset_seen |=> wc[1]; endproperty
    a_kick: assert property (p_kick) else $error("kick");
    property p_off; (open_w && !ctrl_wdata[1]) || supply_monitor_irq || (wdt_reset_seen && !wc[3]) |=> !wc[1];
    endproperty
    a_off: assert property (p_off) else $error("off");
    property p_stat; wc[2] && !(open_w && !ctrl_wdata[2]) |=> wc[2]; endproperty
    a_stat: assert property (p_stat) else $error("status");
    c_rst: cover property (wdt_system_reset);
    c_irq: cover property (wdt_irq);
    c_wr: cover property (open_w);
endmodule : wdc_watchdog_checker
bind wdc_watchdog wdc_watchdog_checker u_chk (.*);
`default_nettype wire

// ### sim/watchdog_control_unit_tb.sv
// Bench for the watchdog control unit.
// Drives inputs at the falling clock edge.
`timescale 1ns/10ps
`default_nettype none
`define CHK(n,e,a) begin tests_run++; if ((a) !== (e)) begin n_mismatch++; $display("MISMATCH %s %h %h", n, e, a); end end
module watchdog_control_unit_tb;
    logic clk = 0, rst = 1, instr_done = 0, ctrl_wr = 0, supply_monitor_irq = 0, wdt_reset_seen = 0;
    logic [7:0] ctrl_wdata = 8'h00, watchdog_control;
    logic wdt_system_reset, wdt_irq, wdt_irq_high_prio;
    int n_mismatch = 0, tests_run = 0, i;
    always #2.5 clk = ~clk;
    wdc_watchdog #(.PERIOD_CYCLES(32'h10)) DUT (
        .clk(clk), .rst(rst), .instr_done(instr_done), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata),
        .supply_monitor_irq(supply_monitor_irq), .wdt_reset_seen(wdt_reset_seen),
        .watchdog_control(watchdog_control), .wdt_system_reset(wdt_system_reset),
        .wdt_irq(wdt_irq), .wdt_irq_high_prio(wdt_irq_high_prio));
    task automatic stop_test;
        if (n_mismatch == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : stop_test
    task automatic wr(input logic [7:0] a, input logic [7:0] b, input bit two);
        ctrl_wr = 1;
        ctrl_wdata = a;
        @(negedge clk);
        if (two) begin
            ctrl_wdata = b;
            @(negedge clk);
        end
        ctrl_wr = 0;
        @(negedge clk);
    endtask : wr
    task automatic wt(input bit irq);
        for (i = 0; i < 40 && !(irq ? wdt_irq : wdt_system_reset); i++) @(negedge clk);
    endtask : wt
    initial begin
        repeat (12) @(negedge clk);
        rst = 0;
        `CHK("ctrl", 8'h10, watchdog_control)
        wr(8'h0a, 8'h00, 0);
        `CHK("ctrl", 8'h10, watchdog_control)
        wr(8'h01, 8'h00, 0);
        `CHK("ctrl", 8'h11, watchdog_control)
        instr_done = 1;
        @(negedge clk);
        instr_done = 0;
        wr(8'h0a, 8'h00, 0);
        `CHK("ctrl", 8'h10, watchdog_control)
        for (int k = 0; k < 8; k++) wr(8'h01, 8'h02, 1);
        `CHK("ctrl", 8'h02, watchdog_control)
        wt(0);
        `CHK("rst", 1'b1, wdt_system_reset)
        `CHK("ctrl", 8'h04, watchdog_control)
        wdt_reset_seen = 1;
        @(negedge clk);
        wdt_reset_seen = 0;
        `CHK("ctrl", 8'h04, watchdog_control)
        `CHK("rst", 1'b0, wdt_system_reset)
        wr(8'h01, 8'h0a, 1);
        `CHK("ctrl", 8'h0a, watchdog_control)
        wt(1);
        `CHK("prio", 1'b1, wdt_irq_high_prio)
        `CHK("irq", 1'b1, wdt_irq)
        `CHK("ctrl", 8'h0e, watchdog_control)
        supply_monitor_irq = 1;
        @(negedge clk);
        supply_monitor_irq = 0;
        @(negedge clk);
        `CHK("ctrl", 8'h0c, watchdog_control)
        `CHK("irq", 1'b0, wdt_irq)
        wr(8'h01, 8'h02, 1);
        wr(8'h01, 8'h00, 1);
        `CHK("ctrl", 8'h00, watchdog_control)
        stop_test();
    end
    initial begin
        #5000;
        n_mismatch++;
        stop_test();
    end
endmodule : watchdog_control_unit_tb
`default_nettype wire
